// File: hdl/hbi_host_port.sv
// Host access port: parallel 6800/8080 style or write-only serial
`timescale 1ns/1ns
module hbi_host_port
  import hbi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ser_par_sel,
  input  wire logic       host_bus_family_sel,
  input  wire logic       chip_select_n,
  input  wire logic       init_clear_n,
  input  wire logic       dc_sel,
  input  wire logic       rd_en_pin,
  input  wire logic       wr_rw_pin,
  input  wire logic [7:0] d_in,
  output logic      [7:0] d_out,
  output logic      [7:0] d_oe,
  input  wire logic [3:0] status_flags,
  input  wire logic [7:0] disp_rd_data,
  output logic            wr_vld,
  output hbi_byte_t       wr_byte,
  output logic            rd_done,
  output logic            rd_done_is_data,
  output logic            clearing
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  hbi_pin_t pin_raw;
  hbi_pin_t s;
  hbi_pin_t s_q_r;

  assign pin_raw = '{ps: ser_par_sel, fam: host_bus_family_sel, cs_n: chip_select_n,
                     clr_n: init_clear_n, dc: dc_sel, strb_a: rd_en_pin,
                     strb_b: wr_rw_pin, d: d_in};

  hbi_sync #(
    .W   ($bits(hbi_pin_t)),
    .RST (HBI_PIN_RST)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pin_raw),
    .q     (s)
  );

  // Previous sample, for strobe edges and for data held during the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q_r <= HBI_PIN_RST;
    end else begin
      s_q_r <= s;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire clr     = ~s.clr_n;
  wire par     = s.ps;
  wire fam68   = s.fam;
  wire sel     = ~s.cs_n;
  wire sel_q   = ~s_q_r.cs_n;

  // Separate strobes: write taken when the write strobe rises under select
  wire wr80    = par & ~fam68 & sel_q & ~s_q_r.strb_b & s.strb_b;
  // Enable+R/W: write closes on the falling enable with R/W low
  wire wr68    = par & fam68 & sel_q & s_q_r.strb_a & ~s.strb_a
                 & ~s_q_r.strb_b;
  // Read window; serial mode never opens one
  wire rd80    = ~fam68 & ~s.strb_a;
  wire rd68    = fam68 & s.strb_a & s.strb_b;
  wire rd_act  = par & sel & (rd80 | rd68);

  wire       ser_en = ~par & sel & ~clr;
  logic      ser_vld;
  hbi_byte_t ser_byte;

  hbi_ser_rx u_ser (
    .clk      (clk),
    .rst_b    (rst_b),
    .en       (ser_en),
    .sclk     (s.d[HBI_SCLK_BIT]),
    .sdi      (s.d[HBI_SDI_BIT]),
    .dc       (s.dc),
    .byte_vld (ser_vld),
    .byte_o   (ser_byte)
  );

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Status read puts the flags high and forces the low nibble to zero
  wire [7:0] stat_byte = {status_flags, HBI_STAT_LOW};
  wire [7:0] rd_byte   = s.dc ? disp_rd_data : stat_byte;

  wire       par_wr    = wr80 | wr68;
  wire       wr_vld_nxt = ~clr & (par_wr | ser_vld);
  hbi_byte_t par_byte;
  assign par_byte = '{is_data: s_q_r.dc, data: s_q_r.d};
  hbi_byte_t wr_byte_nxt;
  assign wr_byte_nxt = par_wr ? par_byte : ser_byte;

  wire [7:0] d_oe_nxt    = (rd_act & ~clr) ? HBI_DOE_ALL : HBI_DOE_NONE;
  logic      rd_act_q_r;
  logic      rd_dc_r;
  wire       rd_end      = rd_act_q_r & ~rd_act & ~clr;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Clear pin acts by level: every cycle it is low the state is held clear,
  // so a pulse shorter than one clock may be missed by the synchroniser.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_oe <= HBI_DOE_NONE;
      d_out <= HBI_DOUT_RST;
    end else begin
      d_oe <= d_oe_nxt;
      d_out <= clr ? HBI_DOUT_RST : rd_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_vld  <= 1'b0;
      wr_byte <= HBI_BYTE_RST;
    end else begin
      wr_vld  <= wr_vld_nxt;
      wr_byte <= clr ? HBI_BYTE_RST : (wr_vld_nxt ? wr_byte_nxt : wr_byte);
    end
  end

  // Read end lets the core advance its address after the host has the byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_act_q_r      <= 1'b0;
      rd_dc_r         <= 1'b0;
      rd_done         <= 1'b0;
      rd_done_is_data <= 1'b0;
      clearing        <= 1'b1;
    end else begin
      rd_act_q_r      <= rd_act & ~clr;
      rd_dc_r         <= rd_act ? s.dc : rd_dc_r;
      rd_done         <= rd_end;
      rd_done_is_data <= rd_end ? rd_dc_r : rd_done_is_data;
      clearing        <= clr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_wr_low_selected;
    !s_q_r.strb_b && sel_q && par && !fam68;
  endsequence

  sequence seq_e_fall_write;
    s_q_r.strb_a && !s_q_r.strb_b && sel_q && par && fam68 ##0 !s.strb_a;
  endsequence

  chk_serial_no_drive: assert property (@(posedge clk) disable iff (!rst_b)
    !par |=> d_oe == HBI_DOE_NONE)
    else $error("data lines driven in serial mode");

  chk_deselect_float: assert property (@(posedge clk) disable iff (!rst_b)
    !sel |=> d_oe == HBI_DOE_NONE && !wr_vld)
    else $error("data lines driven while deselected");

  chk_rd80_drive: assert property (@(posedge clk) disable iff (!rst_b)
    par && !fam68 && sel && !s.strb_a && !clr |=> d_oe == HBI_DOE_ALL)
    else $error("read strobe low but bus not driven");

  chk_e_read_drive: assert property (@(posedge clk) disable iff (!rst_b)
    par && fam68 && sel && !clr && s.strb_a && s.strb_b |=> d_oe == HBI_DOE_ALL)
    else $error("enable read cycle did not drive bus");

  chk_e_low_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    par && fam68 && !s.strb_a |=> d_oe == HBI_DOE_NONE)
    else $error("bus driven with enable low");

  chk_wr80_capture: assert property (@(posedge clk) disable iff (!rst_b)
    seq_wr_low_selected ##0 (s.strb_b && !clr) |=>
      wr_vld && wr_byte.data == $past(s_q_r.d) && wr_byte.is_data == $past(s_q_r.dc))
    else $error("write strobe rise did not capture byte");

  chk_e_write_capture: assert property (@(posedge clk) disable iff (!rst_b)
    seq_e_fall_write ##0 !clr |=> wr_vld && wr_byte.data == $past(s_q_r.d))
    else $error("enable fall write not captured");

  chk_status_nibble: assert property (@(posedge clk) disable iff (!rst_b)
    rd_act && !s.dc && !clr |=> d_out[HBI_STAT_LSB-1:0] == HBI_STAT_LOW
      && d_out[7:HBI_STAT_LSB] == $past(status_flags))
    else $error("status byte low nibble not zero");

  chk_deselect_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    s_q_r.cs_n && s.cs_n |=> !wr_vld)
    else $error("write accepted while deselected");

  chk_clear_holds: assert property (@(posedge clk) disable iff (!rst_b)
    clr [*2] |=> !wr_vld && d_oe == HBI_DOE_NONE && wr_byte == HBI_BYTE_RST)
    else $error("state not cleared while clear pin low");

  chk_serial_no_read: assert property (@(posedge clk) disable iff (!rst_b)
    !par |=> !rd_act_q_r ##1 !rd_done)
    else $error("read activity in serial mode");

  // ----------------------------------------------------------------
  // Read close, serial hand-over and clear checks
  // ----------------------------------------------------------------
  // A read window is open on one sample and shut on the next. The core
  // relies on rd_done to step its read address, so a lost or doubled
  // pulse would skip or repeat a display byte.
  sequence seq_rd_open_then_shut;
    rd_act && !clr ##1 !rd_act && !clr;
  endsequence

  // Enable falls while R/W stays high: that closes a read, never a write
  sequence seq_e_fall_read;
    s_q_r.strb_a && s_q_r.strb_b && par && fam68 ##0 !s.strb_a;
  endsequence

  // Serial receiver hands over a byte while no parallel write competes
  sequence seq_ser_handover;
    ser_vld && !clr && !par_wr;
  endsequence

  chk_rd_close_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    seq_rd_open_then_shut |=> rd_done && d_oe == HBI_DOE_NONE)
    else $error("read close did not pulse done or release bus");

  chk_rd_close_kind: assert property (@(posedge clk) disable iff (!rst_b)
    seq_rd_open_then_shut |=> rd_done_is_data == $past(s.dc, 2))
    else $error("read done reports wrong data or command kind");

  chk_e_read_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    seq_e_fall_read |=> !wr_vld)
    else $error("enable fall with read level taken as write");

  chk_ser_handover: assert property (@(posedge clk) disable iff (!rst_b)
    seq_ser_handover |=> wr_vld && wr_byte == $past(ser_byte))
    else $error("serial byte not passed to write output");

  chk_wr_pulse_single: assert property (@(posedge clk) disable iff (!rst_b)
    wr_vld |=> !wr_vld)
    else $error("write pulse longer than one cycle");

  chk_oe_lanes_equal: assert property (@(posedge clk) disable iff (!rst_b)
    d_oe == HBI_DOE_ALL || d_oe == HBI_DOE_NONE)
    else $error("data line enables differ between lanes");

  // One low sample of the clear pin must already quiet d_oe, wr_vld and d_out
  chk_clear_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    clr |=> d_oe == HBI_DOE_NONE && !wr_vld && d_out == HBI_DOUT_RST)
    else $error("outputs active while clear pin low");

  chk_clearing_flag: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> clearing == $past(clr))
    else $error("clearing flag does not follow clear pin");

  chk_data_read_value: assert property (@(posedge clk) disable iff (!rst_b)
    rd_act && s.dc && !clr |=> d_out == $past(disp_rd_data))
    else $error("display read returned wrong byte");

  // R/W low with enable high is a write in progress; the bus must stay
  // released or the host and the port would fight over the lines.
  chk_e_write_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    par && fam68 && s.strb_a && !s.strb_b |=> d_oe == HBI_DOE_NONE)
    else $error("bus driven during enable write cycle");

  chk_rd80_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    par && !fam68 && s.strb_a |=> d_oe == HBI_DOE_NONE)
    else $error("bus driven with read strobe high");

endmodule

// File: hdl/hbi_pkg.sv
// Shared constants and carrier types for the host bus interface
package hbi_pkg;

  // ----------------------------------------------------------------
  // Data path layout
  // ----------------------------------------------------------------
  localparam int         HBI_DW          = 8;
  localparam int         HBI_STAT_LSB    = 4;
  localparam logic [3:0] HBI_STAT_LOW    = 4'h0;
  localparam int         HBI_SER_BITS    = 8;
  localparam logic [2:0] HBI_SER_LAST    = 3'h7;
  localparam logic [2:0] HBI_SER_CNT_RST = 3'h0;
  localparam int         HBI_SDI_BIT     = 7;
  localparam int         HBI_SCLK_BIT    = 6;
  localparam logic [7:0] HBI_DOE_ALL     = 8'hff;
  localparam logic [7:0] HBI_DOE_NONE    = 8'h00;
  localparam logic [7:0] HBI_DOUT_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int HBI_CLK_NS      = 40;
  localparam int HBI_RST_MIN_NS  = 1000;
  localparam int HBI_RST_MIN_CYC = (HBI_RST_MIN_NS + HBI_CLK_NS - 1) / HBI_CLK_NS;
  localparam int HBI_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ps;      // High: parallel, low: serial
    logic       fam;     // High: enable + read/write, low: separate strobes
    logic       cs_n;
    logic       clr_n;
    logic       dc;      // High: display data, low: control data
    logic       strb_a;  // E or read strobe
    logic       strb_b;  // R/W or write strobe
    logic [7:0] d;
  } hbi_pin_t;

  typedef struct packed {
    logic       is_data;
    logic [7:0] data;
  } hbi_byte_t;

  localparam hbi_pin_t  HBI_PIN_RST  = 15'h5300;
  localparam hbi_byte_t HBI_BYTE_RST = 9'h000;

endpackage

// File: hdl/hbi_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ns
module hbi_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// File: hdl/hbi_ser_rx.sv
// Write-only serial byte receiver, shift clock sampled by the system clock
`timescale 1ns/1ns
module hbi_ser_rx
  import hbi_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic en,
  input  wire logic sclk,
  input  wire logic sdi,
  input  wire logic dc,
  output logic      byte_vld,
  output hbi_byte_t byte_o
);

  logic       sclk_q_r;
  logic [2:0] cnt_r;
  logic [6:0] sh_r;
  wire        rise = en & sclk & ~sclk_q_r;
  wire        last = (cnt_r == HBI_SER_LAST);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q_r <= 1'b0;
      cnt_r    <= HBI_SER_CNT_RST;
      sh_r     <= 7'h00;
      byte_vld <= 1'b0;
      byte_o   <= HBI_BYTE_RST;
    end else begin
      sclk_q_r <= sclk;
      byte_vld <= rise & last;
      if (!en) begin
        cnt_r <= HBI_SER_CNT_RST;
      end else if (rise) begin
        cnt_r <= cnt_r + 3'h1;
        sh_r  <= {sh_r[5:0], sdi};
        if (last) begin
          byte_o <= '{is_data: dc, data: {sh_r, sdi}};
        end
      end
    end
  end

  chk_ser_eighth_bit: assert property (@(posedge clk) disable iff (!rst_b)
    byte_vld |-> $past(cnt_r) == HBI_SER_LAST && $past(rise))
    else $error("serial byte completed before the eighth clock");

endmodule

// File: tb/hbi_host_mdl.sv
// Host processor model that drives the display module's bus pins
`timescale 1ns/1ns
module hbi_host_mdl
  import hbi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] d_out,
  input  wire logic [7:0] d_oe,
  output hbi_pin_t        pin
);
  hbi_pin_t   drv  = HBI_PIN_RST;
  logic       rel  = 1'b0;
  logic [7:0] last = 8'h00;

  // Released bus shows the inverse of the last value, so a stale read never matches
  always_comb begin
    pin   = drv;
    pin.d = (d_oe & d_out) | (~d_oe & (rel ? ~last : drv.d));
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic clr(input logic lvl);
    drv.clr_n <= lvl;
    tick(30);
  endtask

  // Mode pins change only with the chip deselected and then stay put
  task automatic mode(input logic ps, input logic fam);
    drv.ps     <= ps;
    drv.fam    <= fam;
    drv.strb_a <= ~fam;
    drv.strb_b <= 1'b1;
    drv.d      <= ps ? 8'h00 : 8'h3f;
    tick(6);
  endtask

  task automatic xfer(input logic rd, input logic dc, input logic [7:0] b, input logic cs_n);
    drv.cs_n <= cs_n;
    drv.dc   <= dc;
    drv.d    <= b;
    last     <= b;
    rel      <= rd;
    if (drv.fam) begin
      drv.strb_b <= rd;
      drv.strb_a <= 1'b1;
    end else if (rd) begin
      drv.strb_a <= 1'b0;
    end else begin
      drv.strb_b <= 1'b0;
    end
    tick(8);
  endtask

  task automatic done;
    drv.strb_a <= ~drv.fam;
    drv.strb_b <= 1'b1;
    tick(4);
    drv.cs_n <= 1'b1;
    rel      <= 1'b0;
    tick(4);
  endtask

  // Shift clock rests low between frames; 320 ns period
  task automatic ser(input logic dc, input logic [7:0] b, input int nb);
    drv.cs_n <= 1'b0;
    drv.dc   <= dc;
    for (int i = 7; i > 7 - nb; i--) begin
      drv.d[7] <= b[i];
      drv.d[6] <= 1'b0;
      tick(4);
      drv.d[6] <= 1'b1;
      tick(4);
    end
    drv.d[6] <= 1'b0;
    tick(4);
    drv.cs_n <= 1'b1;
    tick(4);
  endtask
endmodule

// File: tb/hbi_host_port_bench.sv
// Self-checking bench for the host access port
`timescale 1ns/1ns
module hbi_host_port_bench;
  import hbi_pkg::*;
  logic       clk   = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] status_flags = 4'h0;
  logic [7:0] disp_rd_data = 8'h00;
  hbi_pin_t   pin;
  logic [7:0] d_out;
  logic [7:0] d_oe;
  logic       wr_vld;
  logic       rd_done;
  logic       rd_done_is_data;
  logic       last_rd_dc = 1'b0;
  logic       clearing;
  hbi_byte_t  wr_byte;
  hbi_byte_t  last_wr;
  int         n_mismatch = 0;
  int         checked    = 0;
  int         n_wr       = 0;
  int         n_rd       = 0;
  int         n_oe       = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  hbi_host_mdl host_u (.clk(clk), .d_out(d_out), .d_oe(d_oe), .pin(pin));

  hbi_host_port dut_u (
    .clk(clk), .rst_b(rst_b), .ser_par_sel(pin.ps), .host_bus_family_sel(pin.fam),
    .chip_select_n(pin.cs_n), .init_clear_n(pin.clr_n), .dc_sel(pin.dc),
    .rd_en_pin(pin.strb_a), .wr_rw_pin(pin.strb_b), .d_in(pin.d), .d_out(d_out),
    .d_oe(d_oe), .status_flags(status_flags), .disp_rd_data(disp_rd_data),
    .wr_vld(wr_vld), .wr_byte(wr_byte), .rd_done(rd_done),
    .rd_done_is_data(rd_done_is_data),
    .clearing(clearing));

  always @(posedge clk) begin
    if (wr_vld === 1'b1) begin
      n_wr++;
      last_wr <= wr_byte;
    end
    if (rd_done === 1'b1) begin
      n_rd++;
      last_rd_dc <= rd_done_is_data;
    end
    if (d_oe !== 8'h00) n_oe++;
  end

  // ----------------------------------------------------------------
  // Compare and closing
  // ----------------------------------------------------------------
  task automatic cmp_bus(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_byte(input hbi_byte_t got, input hbi_byte_t exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_wr(input logic fam);
    int w;
    w = n_wr;
    host_u.mode(1'b1, fam);
    host_u.xfer(1'b0, 1'b1, 8'ha5, 1'b0);
    host_u.done();
    cmp_byte(last_wr, {1'b1, 8'ha5});
    host_u.xfer(1'b0, 1'b0, 8'h3c, 1'b0);
    host_u.done();
    cmp_byte(last_wr, {1'b0, 8'h3c});
    host_u.xfer(1'b0, 1'b1, 8'h11, 1'b1);
    host_u.done();
    cmp_bus(8'(n_wr - w), 8'h02);
  endtask

  task automatic t_rd(input logic fam);
    int w;
    int r;
    w = n_wr;
    r = n_rd;
    status_flags <= 4'hb;
    disp_rd_data <= 8'h5c;
    host_u.mode(1'b1, fam);
    host_u.xfer(1'b1, 1'b1, 8'h00, 1'b0);
    cmp_bus(d_oe, 8'hff);
    cmp_bus(pin.d, 8'h5c);
    host_u.done();
    cmp_bus(d_oe, 8'h00);
    cmp_bus({7'h00, last_rd_dc}, 8'h01);
    host_u.xfer(1'b1, 1'b0, 8'h00, 1'b0);
    cmp_bus(pin.d, 8'hb0);
    host_u.done();
    cmp_bus({7'h00, last_rd_dc}, 8'h00);
    host_u.xfer(1'b1, 1'b1, 8'h00, 1'b1);
    cmp_bus(d_oe, 8'h00);
    host_u.done();
    cmp_bus(8'(n_rd - r), 8'h02);
    cmp_bus(8'(n_wr - w), 8'h00);
  endtask

  task automatic t_ser;
    int w;
    int o;
    w = n_wr;
    o = n_oe;
    host_u.mode(1'b0, 1'b0);
    host_u.ser(1'b1, 8'hc3, 8);
    cmp_byte(last_wr, {1'b1, 8'hc3});
    host_u.ser(1'b1, 8'h5a, 5);
    host_u.ser(1'b0, 8'h81, 8);
    cmp_byte(last_wr, {1'b0, 8'h81});
    cmp_bus(8'(n_wr - w), 8'h02);
    cmp_bus(8'(n_oe - o), 8'h00);
  endtask

  task automatic t_clr;
    host_u.clr(1'b0);
    cmp_bus({7'h00, clearing}, 8'h01);
    cmp_byte(wr_byte, HBI_BYTE_RST);
    host_u.clr(1'b1);
    cmp_bus({7'h00, clearing}, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    host_u.clr(1'b0);
    host_u.clr(1'b1);
    t_wr(1'b0);
    t_wr(1'b1);
    t_rd(1'b0);
    t_rd(1'b1);
    t_ser();
    t_clr();
    finish_test();
  end

  // About 550 clocks expected; cut off well beyond
  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end
endmodule
